// ==== verilog/spcr_pkg.sv ====
// spcr_pkg: constants shared by the serial port configuration register bank
// assumes an 8-bit register access port and 12-bit register addresses
package spcr_pkg;

  localparam int unsigned SPCR_ADDR_W   = 12;
  localparam int unsigned SPCR_DATA_W   = 8;

  // register addresses
  localparam logic [11:0] SPCR_ADDR_CFG = 12'h000;
  localparam logic [11:0] SPCR_ADDR_REV = 12'h002;
  localparam logic [11:0] SPCR_ADDR_VAR = 12'h003;
  localparam logic [11:0] SPCR_ADDR_RBS = 12'h004;

  // serial_port_config field positions
  localparam int unsigned SPCR_BIT_DIR  = 7;
  localparam int unsigned SPCR_BIT_LSBF = 6;
  localparam int unsigned SPCR_BIT_SRST = 5;
  localparam int unsigned SPCR_BIT_UNUS = 4;
  localparam int unsigned SPCR_MIR_HI   = 3;

  // readback_select field position
  localparam int unsigned SPCR_BIT_RBA  = 0;

  // reset values
  localparam logic [7:0]  SPCR_CFG_RST  = 8'h00;
  localparam logic [7:0]  SPCR_RBS_RST  = 8'h00;
  localparam logic [7:0]  SPCR_RD_NONE  = 8'h00;

  // identity codes; values are arbitrary
  localparam logic [7:0]  SPCR_REV_DEF  = 8'h01;
  localparam logic [7:0]  SPCR_VAR_DEF  = 8'h5A;

  // soft reset self-clear sequencing
  typedef enum logic [1:0] {
    SPCR_SR_IDLE = 2'b00,
    SPCR_SR_WAIT = 2'b01,
    SPCR_SR_HOLD = 2'b10
  } spcr_sr_state_t;

endpackage

// ==== verilog/spcr_regs.sv ====
// spcr_regs: serial port configuration registers of the control port
// assumes a serial front end on clk_sys that decodes frames into byte
// accesses; the serial clock pin arrives raw and is sampled here
// rd_phase and rd_bit come from the frame shifter on clk_sys, unsampled
// the mode pin is expected to be static and is filtered like the clock
// pad tristate buffers sit outside; oe high means this block drives
//
// Overview of operation
// - bit 7 clear: spi read data leaves on the data pin, serial out floats
// - bit 7 set: spi read data on serial out pin, writes on data pin
// - bit 6 clear: shift msb first, address steps downward
// - bit 6 set: shift lsb first, address steps upward
// - bit order and address direction ignored in i2c mode
// - soft reset restores defaults, clears on next sclk after the write
// - in i2c mode soft reset clears on next scl after the write
// - read-only silicon revision register, both modes
// - read-only variant code register
// - readback select clear returns buffer copies
// - readback select set returns active copies
`timescale 1ns/1ps
module spcr_regs
  import spcr_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = SPCR_REV_DEF, // arbitrary value
  parameter logic [7:0] VARIANT_CODE  = SPCR_VAR_DEF  // arbitrary value
) (
  input  wire logic                   clk_sys,        // system clock, 100 MHz
  input  wire logic                   rst,            // synchronous reset, active high
  input  wire logic                   clk_en,         // clock enable, freezes state when low
  input  wire logic                   i2c_mode_pin,   // port mode pin, high selects i2c
  input  wire logic                   sclk_pin,       // serial clock pin (sclk or scl)
  input  wire logic                   reg_wr,         // write strobe from serial front end
  input  wire logic                   reg_rd,         // read strobe from serial front end
  input  wire logic [SPCR_ADDR_W-1:0] reg_addr,       // register address
  input  wire logic [SPCR_DATA_W-1:0] reg_wdata,      // write data
  input  wire logic                   io_update,      // buffer to active transfer pulse
  input  wire logic                   rd_phase,       // front end is shifting read data
  input  wire logic                   rd_bit,         // read data bit from shifter
  output logic      [SPCR_DATA_W-1:0] reg_rdata,      // read data, registered
  output logic                        reg_rvalid,     // read data valid pulse
  output logic                        i2c_mode,       // filtered port mode
  output logic                        lsb_first,      // shift order for spi
  output logic                        addr_incr,      // address step direction for spi
  output logic                        soft_reset,     // soft reset bit, high while set
  output logic                        sdio_o,         // data pin output value
  output logic                        sdio_oe,        // data pin output enable
  output logic                        serial_out_pin_o,  // serial out pin value
  output logic                        serial_out_pin_oe  // serial out pin enable
);

  // pin samplers: three flops, change accepted when stages two and three agree
  logic [2:0] sclk_sync_reg;
  logic [2:0] mode_sync_reg;
  logic       sclk_lvl_reg;
  logic       sclk_lvl_next;
  logic       mode_lvl_reg;
  logic       mode_lvl_next;
  logic       sclk_rise;

  // serial clock sampler
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_sync_reg <= 3'h0;
    end else if (clk_en) begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
    end
  end

  // mode pin sampler
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_sync_reg <= 3'h0;
    end else if (clk_en) begin
      mode_sync_reg <= {mode_sync_reg[1:0], i2c_mode_pin};
    end
  end

  always_comb begin
    sclk_lvl_next = sclk_lvl_reg;
    mode_lvl_next = mode_lvl_reg;
    if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
      sclk_lvl_next = sclk_sync_reg[2];
    end
    if (mode_sync_reg[1] == mode_sync_reg[2]) begin
      mode_lvl_next = mode_sync_reg[2];
    end
  end

  // filtered serial clock level, idle low like the pin, so no edge after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_lvl_reg <= 1'b0;
    end else if (clk_en) begin
      sclk_lvl_reg <= sclk_lvl_next;
    end
  end

  // filtered mode level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_lvl_reg <= 1'b0;
    end else if (clk_en) begin
      mode_lvl_reg <= mode_lvl_next;
    end
  end

  assign sclk_rise = clk_en & sclk_lvl_next & ~sclk_lvl_reg;
  assign i2c_mode  = mode_lvl_reg;

  // access decode
  logic wr_cfg;
  logic wr_rbs;
  logic srst_req;

  assign wr_cfg   = clk_en & reg_wr & (reg_addr == SPCR_ADDR_CFG);
  assign wr_rbs   = clk_en & reg_wr & (reg_addr == SPCR_ADDR_RBS);
  assign srst_req = wr_cfg & reg_wdata[SPCR_BIT_SRST];

  // soft reset sequencing: write completes, then the next serial clock clears
  spcr_sr_state_t sr_state_reg;
  spcr_sr_state_t sr_state_next;
  logic           sr_clear;

  always_comb begin
    sr_state_next = sr_state_reg;
    sr_clear      = 1'b0;
    case (sr_state_reg)
      SPCR_SR_IDLE: begin
        if (srst_req) begin
          sr_state_next = SPCR_SR_WAIT;
        end
      end
      SPCR_SR_WAIT: begin
        // the write strobe marks completion; wait for the following edge
        if (sclk_rise) begin
          sr_state_next = SPCR_SR_HOLD;
        end
      end
      SPCR_SR_HOLD: begin
        // set wins: a fresh soft reset write restarts the wait
        sr_clear      = 1'b1;
        sr_state_next = SPCR_SR_IDLE;
        if (srst_req) begin
          sr_state_next = SPCR_SR_WAIT;
        end
      end
      default: begin
        sr_state_next = SPCR_SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sr_state_reg <= SPCR_SR_IDLE;
    end else if (clk_en) begin
      sr_state_reg <= sr_state_next;
    end
  end

  // serial_port_config: acts at once since it shapes the framing itself
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (sr_clear) begin
      cfg_next[SPCR_BIT_SRST] = 1'b0;
    end
    if (wr_cfg) begin
      cfg_next = reg_wdata;
      cfg_next[SPCR_BIT_UNUS] = 1'b0;
      if (reg_wdata[SPCR_BIT_SRST]) begin
        cfg_next = SPCR_CFG_RST;
        cfg_next[SPCR_BIT_SRST] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_reg <= SPCR_CFG_RST;
    end else if (clk_en) begin
      cfg_reg <= cfg_next;
    end
  end

  assign soft_reset = cfg_reg[SPCR_BIT_SRST];

  // bit order and step direction, spi only
  // built from next values so they move in the same cycle as cfg_reg and i2c_mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lsb_first <= 1'b0;
      addr_incr <= 1'b0;
    end else if (clk_en) begin
      lsb_first <= cfg_next[SPCR_BIT_LSBF] & ~mode_lvl_next;
      addr_incr <= cfg_next[SPCR_BIT_LSBF] & ~mode_lvl_next;
    end
  end

  // readback_select: buffer copy written serially, active copy on update
  logic [7:0] rbs_buf_reg;
  logic [7:0] rbs_buf_next;
  logic [7:0] rbs_act_reg;

  // only the select bit is stored, the other bits read as zero
  always_comb begin
    rbs_buf_next               = SPCR_RBS_RST;
    rbs_buf_next[SPCR_BIT_RBA] = reg_wdata[SPCR_BIT_RBA];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rbs_buf_reg <= SPCR_RBS_RST;
    end else if (clk_en) begin
      if (srst_req) begin
        rbs_buf_reg <= SPCR_RBS_RST;
      end else if (wr_rbs) begin
        rbs_buf_reg <= rbs_buf_next;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rbs_act_reg <= SPCR_RBS_RST;
    end else if (clk_en) begin
      if (srst_req) begin
        rbs_act_reg <= SPCR_RBS_RST;
      end else if (io_update) begin
        rbs_act_reg <= rbs_buf_reg;
      end
    end
  end

  // readback: the active select bit chooses which copy is returned
  logic       rd_active;
  logic [7:0] rd_mux;

  assign rd_active = rbs_act_reg[SPCR_BIT_RBA];

  always_comb begin
    case (reg_addr)
      SPCR_ADDR_CFG: rd_mux = cfg_reg;
      SPCR_ADDR_REV: rd_mux = REVISION_CODE;
      SPCR_ADDR_VAR: rd_mux = VARIANT_CODE;
      SPCR_ADDR_RBS: rd_mux = rd_active ? rbs_act_reg : rbs_buf_reg;
      default:       rd_mux = SPCR_RD_NONE;
    endcase
  end

  // read strobe answered exactly one cycle later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= SPCR_RD_NONE;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // data pin steering during the read phase of an spi frame
  logic spi_read;

  assign spi_read = rd_phase & ~mode_lvl_reg;

  // pin data trails the shifter bit by one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sdio_o           <= 1'b0;
      serial_out_pin_o <= 1'b0;
    end else if (clk_en) begin
      sdio_o           <= rd_bit;
      serial_out_pin_o <= rd_bit;
    end
  end

  // at most one pin drives, and only while an spi read is shifting out
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sdio_oe           <= 1'b0;
      serial_out_pin_oe <= 1'b0;
    end else if (clk_en) begin
      if (cfg_reg[SPCR_BIT_DIR]) begin
        sdio_oe           <= 1'b0;
        serial_out_pin_oe <= spi_read;
      end else begin
        sdio_oe           <= spi_read;
        serial_out_pin_oe <= 1'b0;
      end
    end
  end

endmodule

// ==== dv/spcr_regs_props.sv ====
// checker for the serial port configuration register bank
// bound to spcr_regs, sees its ports only
`timescale 1ns/1ps
module spcr_regs_props
  import spcr_pkg::*;
(
  input wire logic        clk_sys,           // system clock
  input wire logic        rst,               // synchronous reset, active high
  input wire logic        clk_en,            // clock enable
  input wire logic        reg_wr,            // write strobe
  input wire logic        reg_rd,            // read strobe
  input wire logic        rd_phase,          // spi read phase
  input wire logic        rd_bit,            // read data bit
  input wire logic        sclk_pin,          // raw serial clock
  input wire logic [11:0] reg_addr,          // register address
  input wire logic [7:0]  reg_wdata,         // write data
  input wire logic [7:0]  reg_rdata,         // read data
  input wire logic        reg_rvalid,        // read data valid
  input wire logic        i2c_mode,          // filtered mode
  input wire logic        lsb_first,         // bit order
  input wire logic        addr_incr,         // address step
  input wire logic        soft_reset,        // soft reset bit
  input wire logic        sdio_oe,           // data pin enable
  input wire logic        serial_out_pin_o,  // serial out value
  input wire logic        serial_out_pin_oe  // serial out enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rev;
    clk_en && reg_rd && reg_addr == SPCR_ADDR_REV |=> reg_rvalid && reg_rdata == SPCR_REV_DEF;
  endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");
  property p_var;
    clk_en && reg_rd && reg_addr == SPCR_ADDR_VAR |=> reg_rvalid && reg_rdata == SPCR_VAR_DEF;
  endproperty
  a_var: assert property (p_var) else $error("variant read wrong");
  property p_rv;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  a_rv: assert property (p_rv) else $error("read valid without read");
  property p_srs;
    clk_en && reg_wr && reg_addr == SPCR_ADDR_CFG && reg_wdata[SPCR_BIT_SRST] |=> soft_reset;
  endproperty
  a_srs: assert property (p_srs) else $error("soft reset not set");
  property p_src;
    soft_reset && $rose(sclk_pin) |-> ##[1:8] !soft_reset;
  endproperty
  a_src: assert property (p_src) else $error("soft reset not cleared");
  property p_i2c;
    i2c_mode |-> !lsb_first && !addr_incr;
  endproperty
  a_i2c: assert property (p_i2c) else $error("bit order used in i2c");
  property p_ord;
    lsb_first == addr_incr;
  endproperty
  a_ord: assert property (p_ord) else $error("order and step differ");
  property p_oe;
    sdio_oe || serial_out_pin_oe |-> !(sdio_oe && serial_out_pin_oe) && $past(rd_phase);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enables wrong");
  property p_dat;
    serial_out_pin_oe |-> serial_out_pin_o == $past(rd_bit);
  endproperty
  a_dat: assert property (p_dat) else $error("serial out data wrong");
endmodule
bind spcr_regs spcr_regs_props chk (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .rd_phase(rd_phase), .rd_bit(rd_bit), .sclk_pin(sclk_pin),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .i2c_mode(i2c_mode), .lsb_first(lsb_first),
  .addr_incr(addr_incr), .soft_reset(soft_reset), .sdio_oe(sdio_oe),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe));

// ==== dv/spcr_host_model.sv ====
// host side serial clock source
// clock runs at 80 ns only while run is high, low between frames
`timescale 1ns/1ps
module spcr_host_model (
  input  wire logic run,       // host inside a frame
  output logic      sclk_pin   // serial clock
);
  initial begin
    sclk_pin = 1'b0;
    #3;
    forever begin
      #40;
      sclk_pin = run ? ~sclk_pin : 1'b0;
    end
  end
endmodule

// ==== dv/spcr_regs_tb_top.sv ====
// testbench for spcr_regs with queued read expectations
// assumes spcr_host_model supplies the serial clock
`timescale 1ns/1ps
module spcr_regs_tb_top;
  import spcr_pkg::*;
  logic        clk_sys, rst, clk_en, i2c_mode_pin, sclk_pin, reg_wr, reg_rd, run;
  logic        io_update, rd_phase, rd_bit, reg_rvalid, i2c_mode, lsb_first, addr_incr;
  logic        soft_reset, sdio_o, sdio_oe, so_o, so_oe;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [7:0]  exp_q[$];
  logic [31:0] lf;
  int          err_total, check_count, cyc;
  spcr_regs uut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .i2c_mode_pin(i2c_mode_pin),
    .sclk_pin(sclk_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .io_update(io_update), .rd_phase(rd_phase), .rd_bit(rd_bit),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .i2c_mode(i2c_mode),
    .lsb_first(lsb_first), .addr_incr(addr_incr), .soft_reset(soft_reset),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe));
  spcr_host_model host (.run(run), .sclk_pin(sclk_pin));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic acc(logic wr, logic [11:0] a, logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic upd;
    @(negedge clk_sys);
    io_update = 1'b1;
    @(negedge clk_sys);
    io_update = 1'b0;
  endtask
  task automatic wsr;
    int n;
    n = 0;
    repeat (8) @(negedge clk_sys);
    chk({7'h00, soft_reset}, 8'h01);
    run = 1'b1;
    while (soft_reset === 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    run = 1'b0;
    chk({7'h00, soft_reset}, 8'h00);
  endtask
  // read results checked in order of issue, timeout cuts a hang
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc > 3000) begin
      err_total++;
      results();
    end else if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(reg_rdata, ~reg_rdata);
      else chk(reg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    {rst, clk_en} = 2'b11;
    {i2c_mode_pin, reg_wr, reg_rd, io_update, rd_phase, rd_bit, run} = 7'h00;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    lf = 32'h00016EF1;
    {err_total, check_count, cyc} = 0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    rd(SPCR_ADDR_CFG, SPCR_CFG_RST);
    rd(SPCR_ADDR_RBS, SPCR_RBS_RST);
    lf = nxt(lf);
    acc(1'b1, SPCR_ADDR_REV, lf[7:0]);
    rd(SPCR_ADDR_REV, SPCR_REV_DEF);
    acc(1'b1, SPCR_ADDR_VAR, lf[15:8]);
    rd(SPCR_ADDR_VAR, SPCR_VAR_DEF);
    rd(12'h001, SPCR_RD_NONE);
    rd_phase = 1'b1;
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, SPCR_ADDR_CFG, i ? 8'h81 : 8'h00);
      lf = nxt(lf);
      rd_bit = lf[0];
      repeat (2) @(negedge clk_sys);
      chk({6'h00, sdio_oe, so_oe}, i ? 8'h01 : 8'h02);
      chk({7'h00, i ? so_o : sdio_o}, {7'h00, lf[0]});
      acc(1'b1, SPCR_ADDR_CFG, i ? 8'h42 : 8'h00);
      @(negedge clk_sys);
      chk({6'h00, lsb_first, addr_incr}, i ? 8'h03 : 8'h00);
    end
    rd(SPCR_ADDR_CFG, 8'h42);
    i2c_mode_pin = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk({5'h00, lsb_first, addr_incr, sdio_oe | so_oe}, 8'h00);
    acc(1'b1, SPCR_ADDR_CFG, 8'h24);
    chk({7'h00, soft_reset}, 8'h01);
    wsr();
    rd(SPCR_ADDR_CFG, SPCR_CFG_RST);
    i2c_mode_pin = 1'b0;
    acc(1'b1, SPCR_ADDR_RBS, 8'h01);
    rd(SPCR_ADDR_RBS, 8'h01);
    upd();
    acc(1'b1, SPCR_ADDR_RBS, 8'h00);
    rd(SPCR_ADDR_RBS, 8'h01);
    upd();
    rd(SPCR_ADDR_RBS, 8'h00);
    @(negedge clk_sys);
    clk_en = 1'b0;
    acc(1'b1, SPCR_ADDR_RBS, 8'h01);
    upd();
    clk_en = 1'b1;
    rd(SPCR_ADDR_RBS, 8'h00);
    acc(1'b1, SPCR_ADDR_RBS, 8'h01);
    upd();
    acc(1'b1, SPCR_ADDR_CFG, 8'h66);
    chk({6'h00, soft_reset, lsb_first}, 8'h02);
    wsr();
    rd(SPCR_ADDR_RBS, SPCR_RBS_RST);
    acc(1'b1, SPCR_ADDR_CFG, 8'h42);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rd(SPCR_ADDR_CFG, SPCR_CFG_RST);
    repeat (4) @(negedge clk_sys);
    chk(8'(exp_q.size()), 8'h00);
    results();
  end
endmodule
